// file: src/frame_counter.sv
`timescale 1ns/100ps
module frame_counter (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic [3:0] bits,
    output logic [3:0] remaining,
    output logic busy,
    output logic last
);
    import serial_pkg::*;

    counter_s q_ff;
    counter_s nxt_q;

    // The first tick of a frame counts its first bit, so one bit remains less.
    always_comb begin
        nxt_q = q_ff;
        last = 1'b0;
        unique case (q_ff.st)
            LINK_IDLE: begin
                if (tick) begin
                    if (bits == 4'h1) begin
                        last = 1'b1;
                    end else begin
                        nxt_q.st = LINK_BUSY;
                        nxt_q.rem = bits - 4'h1;
                    end
                end
            end
            LINK_BUSY: begin
                if (tick) begin
                    nxt_q.rem = q_ff.rem - 4'h1;
                    if (q_ff.rem == 4'h1) begin
                        last = 1'b1;
                        nxt_q.st = LINK_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= '{st: LINK_IDLE, rem: 4'h0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign remaining = q_ff.rem;
    assign busy = (q_ff.st == LINK_BUSY);
endmodule : frame_counter

// file: src/link_sync.sv
`timescale 1ns/100ps
module link_sync #(
    parameter int W = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] pins_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } sync_s;

    sync_s q_ff;
    sync_s nxt_q;

    // The first stage feeds only the second stage; edges come from stages two and three.
    always_comb begin
        nxt_q.meta = pins_in;
        nxt_q.sync = q_ff.meta;
        nxt_q.prev = q_ff.sync;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= '1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign level = q_ff.sync;
    assign rise = q_ff.sync & ~q_ff.prev;
    assign fall = ~q_ff.sync & q_ff.prev;
endmodule : link_sync

// file: src/serial_defs.svh
`ifndef SERIAL_DEFS_SVH
`define SERIAL_DEFS_SVH

// Register offsets on the local register port.
`define OFS_CONTROL 8'h00
`define OFS_IRQ_ENABLE 8'h04
`define OFS_STATUS 8'h08
`define OFS_STATUS_CLEAR 8'h0C
`define OFS_TX_DATA 8'h10
`define OFS_RX_DATA 8'h14
`define OFS_BIT_COUNT 8'h18

// Control register fields.
`define CTL_SYNC_FORMAT 0
`define CTL_TX_MODE 1

// Interrupt enable fields, also the field layout of the status register.
`define IE_TX_EMPTY 7
`define IE_TRANSMIT_END 6
`define IE_RECEIVE_FULL 5
`define IE_NO_ACK 4
`define ST_ARB_LOST 3
`define ST_LOST_BYTE 2

// Reset values.
`define RST_IRQ_ENABLE 4'h0
`define RST_BIT_COUNT 3'h0
`define RST_BYTE 8'h00

`endif

// file: src/serial_irq_core.sv
// What this block does
// - Bit 7 gates transmit empty interrupt
// - Bit 6 gates transmit end interrupt
// - Clearing end flag or enable drops it
// - Bit 5 gates receive full, sync overrun
// - Clearing full flag or enable drops it
// - Bit 4 gates no-ack, lost arbitration, sync overrun
// - Clearing no-ack, lost arbitration, overrun or enable drops it
// - Four enables read/write, reset to zero
// - Code 000 means nine or eight bits
// - Bit count returns to 000 after frame
`timescale 1ns/100ps
`include "serial_defs.svh"
module serial_irq_core (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic arb_lost,
    output serial_pkg::irq_s irq,
    output logic irq_any
);
    import serial_pkg::*;

    logic [1:0] rst_pipe_ff;
    logic rst_n;
    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic scl_rise;
    logic scl_fall;
    logic sda_s;
    logic [3:0] bits;
    logic [3:0] remaining;
    logic busy;
    logic last;
    logic ack_slot;
    logic [7:0] rx_next;
    core_s q_ff;
    core_s nxt_q;
    status_s clr;

    // Reset takes hold asynchronously but is released on the clock.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_ff[1];

    link_sync #(
        .W(2)
    ) u_link_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pins_in({sda_in, scl_in}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign scl_rise = pin_rise[0];
    assign scl_fall = pin_fall[0];
    assign sda_s = pin_level[1];

    assign bits = frame_bits(q_ff.bit_count_field, q_ff.sync_fmt);

    frame_counter u_frame_counter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(scl_rise),
        .bits(bits),
        .remaining(remaining),
        .busy(busy),
        .last(last)
    );

    // The final clock of a two-wire frame carries the acknowledge bit.
    assign ack_slot = !q_ff.sync_fmt && busy && (remaining == 4'h1);

    always_comb begin
        nxt_q = q_ff;
        clr = '0;
        // A frame starts from an empty shifter so short frames come out right-aligned.
        rx_next = {busy ? q_ff.rx_shift_register[6:0] : 7'h00, sda_s};
        nxt_q.rdata = `RST_BYTE;

        if (wr) begin
            unique case (addr)
                `OFS_CONTROL: begin
                    nxt_q.sync_fmt = wdata[`CTL_SYNC_FORMAT];
                    nxt_q.tx_mode = wdata[`CTL_TX_MODE];
                end
                `OFS_IRQ_ENABLE: begin
                    nxt_q.ie = wdata[`IE_TX_EMPTY:`IE_NO_ACK];
                end
                `OFS_STATUS_CLEAR: begin
                    clr.tx_data_empty_flag = wdata[`IE_TX_EMPTY];
                    clr.transmit_end_flag = wdata[`IE_TRANSMIT_END];
                    clr.rx_buffer_full_flag = wdata[`IE_RECEIVE_FULL];
                    clr.no_ack_flag = wdata[`IE_NO_ACK];
                    clr.arbitration_lost_flag = wdata[`ST_ARB_LOST];
                    clr.receive_lost_byte_flag = wdata[`ST_LOST_BYTE];
                end
                `OFS_TX_DATA: begin
                    nxt_q.tx_data = wdata;
                    nxt_q.tx_full = 1'b1;
                    clr.tx_data_empty_flag = 1'b1;
                    clr.transmit_end_flag = 1'b1;
                end
                `OFS_BIT_COUNT: begin
                    // A new count only takes effect between frames.
                    if (!busy) begin
                        nxt_q.bit_count_field = wdata[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        if (rd) begin
            unique case (addr)
                `OFS_CONTROL: begin
                    nxt_q.rdata = {6'h00, q_ff.tx_mode, q_ff.sync_fmt};
                end
                `OFS_IRQ_ENABLE: begin
                    nxt_q.rdata = {q_ff.ie, 4'h0};
                end
                `OFS_STATUS: begin
                    nxt_q.rdata = {q_ff.flags, 2'h0};
                end
                `OFS_TX_DATA: begin
                    nxt_q.rdata = q_ff.tx_data;
                end
                `OFS_RX_DATA: begin
                    nxt_q.rdata = q_ff.rx_buffer_register;
                    clr.rx_buffer_full_flag = 1'b1;
                end
                `OFS_BIT_COUNT: begin
                    nxt_q.rdata = {5'h00, q_ff.bit_count_field};
                end
                default: begin
                end
            endcase
        end

        // Software clears first; hardware events below override them.
        nxt_q.flags = q_ff.flags & ~clr;

        // The fall that opens a frame comes before its first rise and must not shift.
        if (scl_fall && q_ff.tx_active && busy) begin
            nxt_q.tx_shift = {q_ff.tx_shift[6:0], 1'b1};
        end

        if (scl_rise && !ack_slot) begin
            nxt_q.rx_shift_register = rx_next;
        end

        if (scl_rise && ack_slot && q_ff.tx_mode && sda_s) begin
            nxt_q.flags.no_ack_flag = 1'b1;
        end

        if (last) begin
            nxt_q.bit_count_field = `RST_BIT_COUNT;
            nxt_q.tx_active = 1'b0;
            if (q_ff.tx_mode && nxt_q.flags.tx_data_empty_flag) begin
                nxt_q.flags.transmit_end_flag = 1'b1;
            end
            if (!q_ff.tx_mode) begin
                if (q_ff.flags.rx_buffer_full_flag) begin
                    nxt_q.flags.receive_lost_byte_flag = 1'b1;
                end else begin
                    nxt_q.rx_buffer_register = q_ff.sync_fmt ? rx_next : q_ff.rx_shift_register;
                    nxt_q.flags.rx_buffer_full_flag = 1'b1;
                end
            end
        end

        // Loading the shifter empties the data register and raises the empty flag.
        if (q_ff.tx_mode && q_ff.tx_full && !q_ff.tx_active && !busy && !last) begin
            nxt_q.tx_shift = q_ff.tx_data;
            nxt_q.tx_full = 1'b0;
            nxt_q.tx_active = 1'b1;
            nxt_q.flags.tx_data_empty_flag = 1'b1;
        end

        if (arb_lost) begin
            nxt_q.flags.arbitration_lost_flag = 1'b1;
        end

        // Open drain: the line is only ever pulled low.
        if (q_ff.tx_mode) begin
            nxt_q.sda_oe = nxt_q.tx_active && !ack_slot && !nxt_q.tx_shift[7];
        end else begin
            nxt_q.sda_oe = ack_slot;
        end

        // Requests follow the next flags so a clear withdraws them at once.
        nxt_q.irq.tx_empty_irq = nxt_q.ie[3] && nxt_q.flags.tx_data_empty_flag;
        nxt_q.irq.transmit_end_irq = nxt_q.ie[2]
            && nxt_q.flags.transmit_end_flag;
        nxt_q.irq.rx_full_irq = nxt_q.ie[1] && nxt_q.flags.rx_buffer_full_flag;
        nxt_q.irq.error_irq = nxt_q.sync_fmt && nxt_q.flags.receive_lost_byte_flag
            && (nxt_q.ie[1] || nxt_q.ie[0]);
        nxt_q.irq.no_ack_irq = nxt_q.ie[0] && (nxt_q.flags.no_ack_flag
            || nxt_q.flags.arbitration_lost_flag
            || (nxt_q.sync_fmt && nxt_q.flags.receive_lost_byte_flag));
        nxt_q.irq_any = |nxt_q.irq;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign rdata = q_ff.rdata;
    assign sda_out = 1'b0;
    assign sda_oe = q_ff.sda_oe;
    assign irq = q_ff.irq;
    assign irq_any = q_ff.irq_any;
endmodule : serial_irq_core

// file: src/serial_pkg.sv
package serial_pkg;

    typedef enum logic {
        LINK_IDLE = 1'b0,
        LINK_BUSY = 1'b1
    } link_state_e;

    typedef struct packed {
        logic tx_empty_irq;
        logic transmit_end_irq;
        logic rx_full_irq;
        logic error_irq;
        logic no_ack_irq;
    } irq_s;

    typedef struct packed {
        logic tx_data_empty_flag;
        logic transmit_end_flag;
        logic rx_buffer_full_flag;
        logic no_ack_flag;
        logic arbitration_lost_flag;
        logic receive_lost_byte_flag;
    } status_s;

    typedef struct packed {
        link_state_e st;
        logic [3:0] rem;
    } counter_s;

    typedef struct packed {
        logic sync_fmt;
        logic tx_mode;
        logic [3:0] ie;
        status_s flags;
        logic [2:0] bit_count_field;
        logic [7:0] tx_data;
        logic tx_full;
        logic [7:0] tx_shift;
        logic tx_active;
        logic [7:0] rx_shift_register;
        logic [7:0] rx_buffer_register;
        logic [7:0] rdata;
        logic sda_oe;
        irq_s irq;
        logic irq_any;
    } core_s;

    // Number of clock periods in one frame for a bit count code.
    function automatic logic [3:0] frame_bits(input logic [2:0] code, input logic sync);
        if (code == 3'h0) begin
            return sync ? 4'h8 : 4'h9;
        end
        return sync ? {1'b0, code} : {1'b0, code} + 4'h1;
    endfunction : frame_bits

endpackage : serial_pkg

// file: verif/serial_irq_checker.sv
`timescale 1ns/100ps
`include "serial_defs.svh"
module serial_irq_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic arb_lost,
    input wire serial_pkg::irq_s irq
);
    import serial_pkg::*;
    logic [3:0] ie_ff;
    logic sync_ff;
    wire ie_wr = wr && addr == `OFS_IRQ_ENABLE;
    // Shadow copies let the tx empty, rx full and error gates be judged against what software last wrote.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ie_ff <= 4'h0;
            sync_ff <= 1'b0;
        end else begin
            if (ie_wr) begin
                ie_ff <= wdata[7:4];
            end
            if (wr && addr == `OFS_CONTROL) begin
                sync_ff <= wdata[`CTL_SYNC_FORMAT];
            end
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence s_ie_read;
        rd && addr == `OFS_IRQ_ENABLE;
    endsequence
    sequence s_nak_up;
        ##[1:2] irq.no_ack_irq;
    endsequence
    property p_tx_gate;
        irq.tx_empty_irq |-> ie_ff[3];
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx empty irq masked");
    property p_te_drop;
        ie_wr && !wdata[6] |=> !irq.transmit_end_irq;
    endproperty
    a_te_drop: assert property (p_te_drop) else $error("end irq kept");
    property p_rx_gate;
        irq.rx_full_irq |-> ie_ff[1];
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx irq masked");
    property p_err_gate;
        irq.error_irq |-> sync_ff && (ie_ff[1] || ie_ff[0]);
    endproperty
    a_err_gate: assert property (p_err_gate) else $error("error irq masked");
    property p_rx_drop;
        (ie_wr && !wdata[5]) || (rd && addr == `OFS_RX_DATA) |=> !irq.rx_full_irq;
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("rx irq kept");
    property p_nak_up;
        arb_lost && ie_ff[0] && !wr |-> s_nak_up;
    endproperty
    a_nak_up: assert property (p_nak_up) else $error("no ack irq missing");
    property p_nak_drop;
        ie_wr && !wdata[4] |=> !irq.no_ack_irq;
    endproperty
    a_nak_drop: assert property (p_nak_drop) else $error("no ack irq kept");
    property p_ie_read;
        s_ie_read |=> rdata == {ie_ff, 4'h0};
    endproperty
    a_ie_read: assert property (p_ie_read) else $error("enable readback wrong");
endmodule : serial_irq_checker
bind serial_irq_core serial_irq_checker i_serial_irq_checker (.clk_sys(clk_sys), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .arb_lost(arb_lost),
    .irq(irq));

// file: verif/serial_peer.sv
`timescale 1ns/100ps
module serial_peer (
    output logic scl,
    output logic sda,
    input wire logic sda_in
);
    // The clock stands high between frames so no stray edge opens a frame.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Bits go out MSB first; a 1 lets go of the line so the block may pull it.
    task automatic frame(input int n, input int hp, input logic [8:0] ob,
        output logic [8:0] ib);
        ib = 9'h000;
        for (int i = n - 1; i >= 0; i--) begin
            scl = 1'b0;
            #(hp / 2);
            sda = ob[i];
            #(hp - hp / 2);
            scl = 1'b1;
            ib[i] = sda_in;
            #hp;
        end
        sda = 1'b1;
    endtask : frame
endmodule : serial_peer

// file: verif/tb_serial_irq_core.sv
`timescale 1ns/100ps
`include "serial_defs.svh"
module tb_serial_irq_core;
    import serial_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, arb_lost = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, st = 8'h00;
    logic [3:0] ie = 4'h0;
    logic sy = 1'b0;
    logic scl, sda_pk, sda_out, sda_oe, irq_any;
    logic [8:0] got;
    irq_s irq;
    integer errors = 0, n_compared = 0, seed = 32'h37C4BDDF, c, n, v;
    // The data line has a pull-up, so whoever lets go leaves it high.
    wire sda = sda_pk & ~(sda_oe & ~sda_out);
    serial_irq_core i_serial_irq_core (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .arb_lost(arb_lost), .irq(irq), .irq_any(irq_any));
    serial_peer i_serial_peer (.scl(scl), .sda(sda_pk), .sda_in(sda));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    function automatic irq_s exp_irq();
        irq_s e;
        e.tx_empty_irq = ie[3] & st[7];
        e.transmit_end_irq = ie[2] & st[6];
        e.rx_full_irq = ie[1] & st[5];
        e.error_irq = sy & st[2] & (ie[1] | ie[0]);
        e.no_ack_irq = ie[0] & (st[4] | st[3] | (sy & st[2]));
        return e;
    endfunction : exp_irq
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk_sys);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] x);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        x = rdata;
    endtask : rd_reg
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
        chk(9'(irq), 9'(exp_irq()));
        chk(9'(irq_any), 9'(|9'(exp_irq())));
        rd_reg(`OFS_STATUS, d);
        chk(9'(d), 9'(st));
    endtask : settle
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #1000000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_reg(`OFS_IRQ_ENABLE, d);
        chk(9'(d), 9'h000);
        rd_reg(8'hFC, d);
        chk(9'(d), 9'h000);
        settle();
        for (c = 0; c < 6; c++) begin
            v = $random(seed);
            wr_reg(`OFS_IRQ_ENABLE, v[7:0]);
            ie = v[7:4];
            rd_reg(`OFS_IRQ_ENABLE, d);
            chk(9'(d), {1'b0, ie, 4'h0});
        end
        wr_reg(`OFS_IRQ_ENABLE, 8'hF0);
        ie = 4'hF;
        wr_reg(`OFS_CONTROL, 8'h02);
        v = $random(seed);
        wr_reg(`OFS_TX_DATA, v[7:0]);
        st[7] = 1'b1;
        settle();
        i_serial_peer.frame(9, 160, 9'h1FE, got);
        chk(got, {v[7:0], 1'b0});
        st[6] = 1'b1;
        settle();
        rd_reg(`OFS_BIT_COUNT, d);
        chk(9'(d), 9'h000);
        wr_reg(`OFS_IRQ_ENABLE, 8'h30);
        ie = 4'h3;
        settle();
        wr_reg(`OFS_IRQ_ENABLE, 8'h70);
        ie = 4'h7;
        wr_reg(`OFS_STATUS_CLEAR, 8'h40);
        st[6] = 1'b0;
        settle();
        v = $random(seed);
        wr_reg(`OFS_TX_DATA, v[7:0]);
        i_serial_peer.frame(9, 160, 9'h1FF, got);
        chk(got, {v[7:0], 1'b1});
        st[6] = 1'b1;
        st[4] = 1'b1;
        settle();
        wr_reg(`OFS_STATUS_CLEAR, 8'h50);
        st[6] = 1'b0;
        st[4] = 1'b0;
        settle();
        @(posedge clk_sys);
        arb_lost <= 1'b1;
        @(posedge clk_sys);
        arb_lost <= 1'b0;
        st[3] = 1'b1;
        settle();
        wr_reg(`OFS_IRQ_ENABLE, 8'h20);
        ie = 4'h2;
        settle();
        wr_reg(`OFS_STATUS_CLEAR, 8'h08);
        st[3] = 1'b0;
        for (c = 0; c < 16; c++) begin
            sy = c[3];
            wr_reg(`OFS_CONTROL, {7'h00, sy});
            wr_reg(`OFS_BIT_COUNT, {5'h00, c[2:0]});
            n = (c[2:0] == 3'h0) ? 8 : c[2:0];
            v = $random(seed);
            i_serial_peer.frame(n + !sy, 160, sy ? 9'(v) : {v[7:0], 1'b1}, got);
            st[5] = 1'b1;
            settle();
            chk(9'(got[0] & ~sy), 9'h000);
            rd_reg(`OFS_BIT_COUNT, d);
            chk(9'(d), 9'h000);
            rd_reg(`OFS_RX_DATA, d);
            chk(9'(d), 9'(v & ((1 << n) - 1)));
            st[5] = 1'b0;
            settle();
        end
        // A second byte before the first is read must be flagged as lost.
        wr_reg(`OFS_BIT_COUNT, 8'h00);
        i_serial_peer.frame(8, 160, 9'h0A5, got);
        i_serial_peer.frame(8, 160, 9'h05A, got);
        st[5] = 1'b1;
        st[2] = 1'b1;
        settle();
        wr_reg(`OFS_IRQ_ENABLE, 8'h10);
        ie = 4'h1;
        settle();
        wr_reg(`OFS_STATUS_CLEAR, 8'h04);
        st[2] = 1'b0;
        settle();
        wr_reg(`OFS_IRQ_ENABLE, 8'h20);
        ie = 4'h2;
        rd_reg(`OFS_RX_DATA, d);
        chk(9'(d), 9'h0A5);
        st[5] = 1'b0;
        settle();
        give_verdict();
    end
endmodule : tb_serial_irq_core
